// ---- hw/cssft_pkg.sv ----
/*
 Package for the conversion signal source select and frame timer block.
 Holds register offsets, field positions, reset values and signal carrier structs.
 Assumes an AXI4-Lite master with 32-bit data on the host side.
*/
package cssft_pkg;
   // Register byte addresses
   localparam logic [11:0] CSSFT_SRC_SEL_OFS = 12'h344;
   localparam logic [11:0] CSSFT_FRAME_TIMER_OFS = 12'h348;
   localparam logic [11:0] CSSFT_IRQ_STATUS_OFS = 12'h34C;
   localparam logic [11:0] CSSFT_IRQ_MASK_OFS = 12'h350;
   // Source select field positions
   localparam int CSSFT_FTRIG_LSB = 4;
   localparam int CSSFT_CLK2_LSB = 2;
   localparam int CSSFT_CLK1_LSB = 0;
   // Frame timer field positions
   localparam int CSSFT_ENA_BIT = 31;
   localparam int CSSFT_CSEL_BIT = 30;
   localparam int CSSFT_STAT_BIT = 29;
   // Reset values
   localparam logic [1:0] CSSFT_SRC_RST = 2'h0;
   localparam logic [27:0] CSSFT_RELOAD_RST = 28'hFFFFFFF;
   // Source codes (0x selects the internal generator)
   localparam logic [1:0] CSSFT_SRC_REAR = 2'h2;
   localparam logic [1:0] CSSFT_SRC_FRONT = 2'h3;
   // AXI response codes
   localparam logic [1:0] CSSFT_RESP_OKAY = 2'h0;
   localparam logic [1:0] CSSFT_RESP_SLVERR = 2'h2;

   // Candidate sources for one conversion control signal
   typedef struct packed {
      logic internal_gen;
      logic rear_input;
      logic front_line;
   } cssft_src_s;

   // Selected conversion control signals toward the sequencers
   typedef struct packed {
      logic frame_trigger;
      logic second_clock;
      logic first_clock;
   } cssft_conv_s;
endpackage : cssft_pkg

// ---- hw/cssft_top.sv ----
/*
 Conversion signal source select and frame timer, with AXI4-Lite registers.
 Holds the source selection, the frame timer and a maskable expiry interrupt.
 Assumes all inputs synchronous to sys_clk; conversion clocks are slower than
 sys_clk and are sampled as enables, not used as clocks.
 Assumes the front line output enables come from the digital I/O block.
*/
`timescale 1ns/1ns

module cssft_top
   import cssft_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cssft_src_s frame_trigger_sources,
   input wire cssft_src_s second_clock_sources,
   input wire cssft_src_s first_clock_sources,
   input wire logic [2:0] front_line_output_enable,
   output cssft_conv_s conv_signals,
   output logic frame_timer_event,
   output logic irq
);

   // Whole block state in one struct
   typedef struct packed {
      // Software-visible register fields
      logic [1:0] frame_trigger_source_sel;
      logic [1:0] second_conversion_clock_source_sel;
      logic [1:0] first_conversion_clock_source_sel;
      logic frame_counter_enable;
      logic frame_counter_clock_sel;
      logic frame_counter_expired_flag;
      logic [27:0] frame_counter_reload_value;
      // Timer working state
      logic [27:0] count;
      logic running;
      // Edge detectors for trigger and counting clock
      logic trig_sync;
      logic trig_seen;
      logic clk_sync;
      logic clk_seen;
      // Selected signals toward the sequencers and expiry pulse
      cssft_conv_s conv;
      logic timer_event;
      // Interrupt status and mask
      logic irq_status;
      logic irq_mask;
      // Write slots for address and data
      logic aw_held;
      logic [11:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      // Registered answers
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cssft_state_s;

   cssft_state_s state_reg;
   cssft_state_s state_next;

   // Pick one source: 0x internal, 10 rear, 11 front line.
   // A front line whose output enable is set is driven by the I/O block,
   // so it reads as low rather than echoing our own output back.
   // Used for all three conversion control signals.
   function automatic logic pick_source(input logic [1:0] sel, input cssft_src_s src,
                                        input logic front_oe);
      logic v;
      v = src.internal_gen;
      if (sel == CSSFT_SRC_REAR)
         v = src.rear_input;
      else if (sel == CSSFT_SRC_FRONT)
         v = src.front_line & ~front_oe; // Driven line is not an input
      return v;
   endfunction : pick_source

   // Frame timer register read view.
   // Bit 29 shows the sticky expiry flag; bit 28 is reserved.
   // Reserved bits read as zero.
   // Shared by the read path only, kept apart for clarity.
   function automatic logic [31:0] timer_word(input cssft_state_s s);
      logic [31:0] w;
      w = 32'h0;
      w[CSSFT_ENA_BIT] = s.frame_counter_enable;
      w[CSSFT_CSEL_BIT] = s.frame_counter_clock_sel;
      w[CSSFT_STAT_BIT] = s.frame_counter_expired_flag;
      w[27:0] = s.frame_counter_reload_value; // Bit 28 reads zero
      return w;
   endfunction : timer_word

   // Next-state logic for selection, timer and bus slave.
   // Latency: a pin change shows on conv_signals one edge later.
   // A trigger or clock rise is acted on three edges after the pin rises:
   // one edge to select, two to detect the edge.
   // Trigger and counting clock share that delay, so counts stay exact.
   // Counting clocks must not exceed half of sys_clk or ticks are lost.
   // Write answers come two edges after both halves are taken.
   // Read answers come one edge after the address is taken.
   always_comb
   begin
      logic trig_edge;
      logic tick;
      logic expire;
      logic wr_go;
      logic [31:0] wd;
      logic [11:0] ra;
      trig_edge = 1'b0;
      tick = 1'b0;
      expire = 1'b0;
      wr_go = 1'b0;
      wd = 32'h0;
      ra = 12'h0;
      state_next = state_reg;
      state_next.timer_event = 1'b0;

      // Source selection registered toward the sequencers
      state_next.conv.frame_trigger = pick_source(state_reg.frame_trigger_source_sel,
         frame_trigger_sources, front_line_output_enable[2]);
      state_next.conv.second_clock = pick_source(state_reg.second_conversion_clock_source_sel,
         second_clock_sources, front_line_output_enable[1]);
      state_next.conv.first_clock = pick_source(state_reg.first_conversion_clock_source_sel,
         first_clock_sources, front_line_output_enable[0]);

      // Edge detection of trigger and counting clock.
      // Detectors reset low, the idle level of every source after reset,
      // so no false edge follows reset.
      // The counting clock is a sampled level, never a clock of flip-flops.
      state_next.trig_sync = state_reg.conv.frame_trigger;
      state_next.trig_seen = state_reg.trig_sync;
      trig_edge = state_reg.trig_sync & ~state_reg.trig_seen;
      state_next.clk_sync = state_reg.frame_counter_clock_sel ? state_reg.conv.second_clock
                                                              : state_reg.conv.first_clock;
      state_next.clk_seen = state_reg.clk_sync;
      tick = state_reg.clk_sync & ~state_reg.clk_seen;

      // Frame timer: a trigger restarts the count, a tick moves it on.
      // Expiry is worked out first so that a trigger on the expiring tick
      // still reports the event: the set of the flag wins over its clear.
      expire = state_reg.frame_counter_enable && state_reg.running && tick
         && (state_reg.count == state_reg.frame_counter_reload_value);
      if (state_reg.frame_counter_enable)
      begin
         if (trig_edge)
         begin
            state_next.count = 28'h0;
            state_next.running = 1'b1;
            state_next.frame_counter_expired_flag = 1'b0;
         end
         else if (expire)
            state_next.running = 1'b0; // Expired timer waits for the next trigger
         else if (tick && state_reg.running)
            state_next.count = state_reg.count + 28'h1;
      end

      // Expiry after reload plus one ticks: pulse, flag and interrupt
      if (expire)
      begin
         state_next.timer_event = 1'b1;
         state_next.frame_counter_expired_flag = 1'b1;
         state_next.irq_status = 1'b1;
      end

      // Write address and data taken in either order.
      // Each half waits in its slot, and its ready stays low while held,
      // so a second write cannot overrun one not yet answered.
      if (s_axi_awvalid && !state_reg.aw_held)
      begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state_reg.w_held)
      begin
         state_next.w_held = 1'b1;
         state_next.w_data = s_axi_wdata;
         state_next.w_strb = s_axi_wstrb;
      end
      // Perform the write once both halves are held and no answer waits
      wr_go = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
      if (wr_go)
      begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = CSSFT_RESP_OKAY;
         wd = state_reg.w_data;
         case ({state_reg.aw_addr[11:2], 2'h0})
            // Reserved bits 31:6 are dropped on write
            CSSFT_SRC_SEL_OFS:
            begin
               if (state_reg.w_strb[0])
               begin
                  state_next.frame_trigger_source_sel = wd[CSSFT_FTRIG_LSB +: 2];
                  state_next.second_conversion_clock_source_sel = wd[CSSFT_CLK2_LSB +: 2];
                  state_next.first_conversion_clock_source_sel = wd[CSSFT_CLK1_LSB +: 2];
               end
            end

            // Byte lanes of the reload value; lane 3 also holds enable and
            // clock select, and the read-only status bit is never written
            CSSFT_FRAME_TIMER_OFS:
            begin
               if (state_reg.w_strb[0])
                  state_next.frame_counter_reload_value[7:0] = wd[7:0];
               if (state_reg.w_strb[1])
                  state_next.frame_counter_reload_value[15:8] = wd[15:8];
               if (state_reg.w_strb[2])
                  state_next.frame_counter_reload_value[23:16] = wd[23:16];
               if (state_reg.w_strb[3])
               begin
                  state_next.frame_counter_reload_value[27:24] = wd[27:24];
                  state_next.frame_counter_enable = wd[CSSFT_ENA_BIT];
                  state_next.frame_counter_clock_sel = wd[CSSFT_CSEL_BIT];
                  if (!wd[CSSFT_ENA_BIT])
                     state_next.running = 1'b0; // Disabled timer stops
               end
            end

            CSSFT_IRQ_STATUS_OFS:
            begin
               // Write one clears, but a new event wins
               if (state_reg.w_strb[0] && wd[0] && !state_next.timer_event)
                  state_next.irq_status = 1'b0;
            end

            CSSFT_IRQ_MASK_OFS:
            begin
               if (state_reg.w_strb[0])
                  state_next.irq_mask = wd[0];
            end
            // Unmapped address: nothing changes, error answer
            default:
               state_next.bresp = CSSFT_RESP_SLVERR;
         endcase
      end
      // Answer leaves once bready is sampled
      if (state_reg.bvalid && s_axi_bready)
         state_next.bvalid = 1'b0;

      // Read channel.
      // The address is taken only while no answer waits, so rdata stands
      // unchanged until the master takes it.
      if (s_axi_arvalid && !state_reg.rvalid)
      begin
         ra = {s_axi_araddr[11:2], 2'h0};
         state_next.rvalid = 1'b1;
         state_next.rresp = CSSFT_RESP_OKAY;
         case (ra)
            CSSFT_SRC_SEL_OFS:
               state_next.rdata = {26'h0, state_reg.frame_trigger_source_sel,
                  state_reg.second_conversion_clock_source_sel,
                  state_reg.first_conversion_clock_source_sel};
            CSSFT_FRAME_TIMER_OFS:
               state_next.rdata = timer_word(state_reg);
            CSSFT_IRQ_STATUS_OFS:
               state_next.rdata = {31'h0, state_reg.irq_status};
            CSSFT_IRQ_MASK_OFS:
               state_next.rdata = {31'h0, state_reg.irq_mask};
            // Unmapped address reads zero with an error answer
            default:
            begin
               state_next.rdata = 32'h0;
               state_next.rresp = CSSFT_RESP_SLVERR;
            end
         endcase
      end
      // Answer leaves once rready is sampled
      else if (state_reg.rvalid && s_axi_rready)
         state_next.rvalid = 1'b0;
   end

   // State register.
   // Reset loads constants only; source fields 00, reload all ones.
   // Everything else, including the bus slots, starts cleared.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= '0;
         state_reg.frame_trigger_source_sel <= CSSFT_SRC_RST;
         state_reg.second_conversion_clock_source_sel <= CSSFT_SRC_RST;
         state_reg.first_conversion_clock_source_sel <= CSSFT_SRC_RST;
         state_reg.frame_counter_reload_value <= CSSFT_RELOAD_RST;
      end
      else
         state_reg <= state_next;
   end

   // Write channel handshakes; readies are free slots
   assign s_axi_awready = !state_reg.aw_held;
   assign s_axi_wready = !state_reg.w_held;
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp = state_reg.bresp;

   // Read channel handshakes
   assign s_axi_arready = !state_reg.rvalid;
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rdata = state_reg.rdata;
   assign s_axi_rresp = state_reg.rresp;

   // Toward the sequencers and the host interrupt line
   assign conv_signals = state_reg.conv;
   assign frame_timer_event = state_reg.timer_event;
   assign irq = state_reg.irq_status & state_reg.irq_mask;
endmodule : cssft_top

// ---- sim/cssft_sva.sv ----
/* Port checker for cssft_top.
 Bound to every cssft_top instance; sees its ports only. */
`timescale 1ns/1ns
module cssft_sva
   import cssft_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cssft_src_s frame_trigger_sources,
   input wire cssft_src_s second_clock_sources,
   input wire cssft_src_s first_clock_sources,
   input wire logic [2:0] front_line_output_enable,
   input wire cssft_conv_s conv_signals,
   input wire logic frame_timer_event
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Address and data taken at one edge
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // Register bus timing
   a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write answer not two cycles after take");
   a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read answer not one cycle after take");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while answer pending");
   // Expiry is a single pulse
   a_event_pulse: assert property (frame_timer_event |=> !frame_timer_event)
      else $error("timer event longer than one cycle");
   // Driven front lines read as zero
   a_front_clk1: assert property (front_line_output_enable[0]
      && !first_clock_sources.rear_input && !first_clock_sources.internal_gen
      |=> !conv_signals.first_clock) else $error("driven line 1 passed as clock");
   a_front_clk2: assert property (front_line_output_enable[1]
      && !second_clock_sources.rear_input && !second_clock_sources.internal_gen
      |=> !conv_signals.second_clock) else $error("driven line 3 passed as clock");
   a_front_trig: assert property (front_line_output_enable[2]
      && !frame_trigger_sources.rear_input && !frame_trigger_sources.internal_gen
      |=> !conv_signals.frame_trigger) else $error("driven line 5 passed as trigger");
endmodule : cssft_sva

bind cssft_top cssft_sva i_cssft_sva (.*);

// ---- sim/cssft_far_src.sv ----
/* Far-side sources: rear and front conversion clocks and frame trigger.
 Levels change after sys_clk rising edges; index 2 trigger, 1 clock 2, 0 clock 1. */
`timescale 1ns/1ns
module cssft_far_src
(
   input wire logic sys_clk,
   input wire logic run,
   input wire logic trig,
   input wire logic [2:0] pat,
   output logic [2:0] rear,
   output logic [2:0] front
);
   int cnt = 0;
   logic [2:0] wave;
   // Clock 1 period 8, clock 2 period 6, trigger follows the request
   assign wave = {trig, (cnt % 6) < 3, (cnt % 8) < 4};
   initial rear = 3'h0;
   initial front = 3'h0;
   // Static pattern while idle, generators while running
   always @(posedge sys_clk)
   begin
      cnt <= cnt + 1;
      rear <= run ? wave : pat;
      front <= run ? wave : ~pat;
   end
endmodule : cssft_far_src

// ---- sim/cssft_top_bench.sv ----
/* Self-checking bench for cssft_top with far-side source model.
 Assumes the checker is bound by its own file. */
`timescale 1ns/1ns
module cssft_top_bench;
   import cssft_pkg::*;
   logic sys_clk = 0, resetn = 0, run = 0, trig = 0, pf = 0, pc = 0, csel = 0, cc;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, sel = 0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq, frame_timer_event;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] ig = 0, front_line_output_enable = 0, pat = 0, rear, front;
   cssft_src_s frame_trigger_sources, second_clock_sources, first_clock_sources;
   cssft_conv_s conv_signals;
   int n_mismatch = 0, n_tests = 0, cyc = 0, seed = 22545, ccount = 0, exp_edges = 0;
   int n_ev = 0, rl = 0;
   assign frame_trigger_sources = {ig[2], rear[2], front[2]};
   assign second_clock_sources = {ig[1], rear[1], front[1]};
   assign first_clock_sources = {ig[0], rear[0], front[0]};
   assign cc = csel ? conv_signals.second_clock : conv_signals.first_clock;
   cssft_top i_cssft_top (.*);
   cssft_far_src i_cssft_far_src (.*);
   initial forever #10 sys_clk = ~sys_clk;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Expected response code for a register address
   function automatic logic [31:0] exp_resp(input logic [11:0] a);
      return (a inside {CSSFT_SRC_SEL_OFS, CSSFT_FRAME_TIMER_OFS, CSSFT_IRQ_STATUS_OFS,
         CSSFT_IRQ_MASK_OFS}) ? {30'h0, CSSFT_RESP_OKAY} : {30'h0, CSSFT_RESP_SLVERR};
   endfunction : exp_resp
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   // Write: offer both channels, drop each once taken, then take the answer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      logic [1:0] rs;
      @(posedge sys_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      tb = 1'b0;
      while (!tb)
      begin
         @(negedge sys_clk);
         ta = s_axi_awready & s_axi_awvalid;
         tw = s_axi_wready & s_axi_wvalid;
         tb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", exp_resp(a), {30'h0, rs});
   endtask : wr
   // Read with a late rready, compared with the expected word and response
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic t;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      t = 1'b0;
      while (!t)
      begin
         @(negedge sys_clk);
         t = s_axi_arready;
         @(posedge sys_clk);
      end
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(negedge sys_clk);
      @(posedge sys_clk);
      s_axi_rready <= 1'b1;
      @(negedge sys_clk);
      chk("rdata", e, s_axi_rdata);
      chk("rresp", exp_resp(a), {30'h0, s_axi_rresp});
      @(posedge sys_clk);
      s_axi_rready <= 1'b0;
   endtask : rc
   // Trigger pulse launched just after a rise of the counting clock
   task automatic fire;
      logic p, c;
      p = 1'b1;
      c = 1'b1;
      while (p | !c)
      begin
         p = c;
         @(negedge sys_clk);
         c = rear[csel];
      end
      @(posedge sys_clk);
      trig <= 1'b1;
      repeat (4) @(posedge sys_clk);
      trig <= 1'b0;
   endtask : fire
   // Selected level of each conversion signal from the select code
   function automatic logic [2:0] exp_conv();
      logic [2:0] e;
      for (int i = 0; i < 3; i++)
         e[i] = sel[2*i+1] ? (sel[2*i] ? front[i] & !front_line_output_enable[i] : rear[i]) : ig[i];
      return e;
   endfunction : exp_conv
   // Counts counting-clock rises since the last trigger, checked at each expiry
   always @(negedge sys_clk)
   begin
      pf <= conv_signals.frame_trigger;
      pc <= cc;
      if (conv_signals.frame_trigger && !pf) ccount <= 0;
      else if (cc && !pc) ccount <= ccount + 1;
      if (frame_timer_event === 1'b1)
      begin
         n_ev++;
         chk("expiry edges", exp_edges, ccount);
      end
   end
   // Cuts a hang short
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         end_sim();
      end
   end
   // Main sequence
   initial
   begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      rc(CSSFT_SRC_SEL_OFS, 32'h0);
      rc(CSSFT_FRAME_TIMER_OFS, 32'h0FFFFFFF);
      rc(12'h000, 32'h0);
      wr(12'h000, 32'hFFFFFFFF);
      rc(CSSFT_SRC_SEL_OFS, 32'h0);
      $display("test reset values done");
      repeat (24)
      begin
         sel = $random(seed);
         wr(CSSFT_SRC_SEL_OFS, sel);
         rc(CSSFT_SRC_SEL_OFS, {26'h0, sel[5:0]});
         repeat (4)
         begin
            @(posedge sys_clk);
            ig <= $random(seed);
            front_line_output_enable <= $random(seed);
            pat <= $random(seed);
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk("conv", {29'h0, exp_conv()}, {29'h0, conv_signals});
         end
      end
      $display("test source select done");
      wr(CSSFT_SRC_SEL_OFS, 32'h2A);
      wr(CSSFT_IRQ_MASK_OFS, 32'h1);
      run <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         rl = ($random(seed) & 7) + 8;
         csel <= k[0];
         wr(CSSFT_FRAME_TIMER_OFS, {1'b1, k[0], 2'h0, rl[27:0]});
         exp_edges = rl + 1;
         fire();
         repeat (4) @(posedge sys_clk);
         rc(CSSFT_FRAME_TIMER_OFS, {1'b1, k[0], 2'h0, rl[27:0]});
         if (k == 1) fire();
         for (int t = 0; t < 300 && n_ev == k; t++) @(posedge sys_clk);
         chk("events", k + 1, n_ev);
         chk("irq", 32'h1, {31'h0, irq});
         wr(CSSFT_FRAME_TIMER_OFS, {1'b1, k[0], 2'h0, rl[27:0]});
         rc(CSSFT_FRAME_TIMER_OFS, {1'b1, k[0], 2'h2, rl[27:0]});
         wr(CSSFT_IRQ_MASK_OFS, 32'h0);
         chk("irq", 32'h0, {31'h0, irq});
         wr(CSSFT_IRQ_MASK_OFS, 32'h1);
         wr(CSSFT_IRQ_STATUS_OFS, 32'h1);
         chk("irq", 32'h0, {31'h0, irq});
      end
      $display("test frame timer done");
      wr(CSSFT_FRAME_TIMER_OFS, {4'h0, rl[27:0]});
      fire();
      repeat (200) @(posedge sys_clk);
      chk("events", 32'h2, n_ev);
      $display("test disabled timer done");
      end_sim();
   end
endmodule : cssft_top_bench
